// File: rtl/mcsd_consts.svh
`ifndef MCSD_CONSTS_SVH
`define MCSD_CONSTS_SVH
// register indexes; the bus byte address is four times the index
`define MCSD_IDX_LOW        8'ha2
`define MCSD_IDX_PERIPH     8'ha4
`define MCSD_IDX_MID        8'ha6
`define MCSD_IDX_AUX        8'ha8
`define MCSD_IDX_STATUS     8'haa
`define MCSD_REG_RST        16'h0000
// common ready and wait fields
`define MCSD_READY_BIT      2
`define MCSD_WAIT_LSB       0
// low-memory register fields
`define MCSD_LOW_UB_LSB     12
`define MCSD_LOW_DA_BIT     7
`define MCSD_LOW_PSE_BIT    6
// midrange and peripheral base fields, and the peripheral wait extension bit
`define MCSD_MID_BASE_LSB   9
`define MCSD_PER_BASE_LSB   7
`define MCSD_PER_EXT_BIT    3
// auxiliary register fields
`define MCSD_AUX_SIZE_LSB   8
`define MCSD_AUX_EX_BIT     7
`define MCSD_AUX_MS_BIT     6
// extended peripheral wait counts for codes 100b to 111b
`define MCSD_PW_CODE4       4'h5
`define MCSD_PW_CODE5       4'h7
`define MCSD_PW_CODE6       4'h9
`define MCSD_PW_CODE7       4'hf
// reserved peripheral position, and the two upper positions
`define MCSD_PER_RSVD_POS   3'h4
`define MCSD_PER_UP0_POS    3'h5
`define MCSD_PER_UP1_POS    3'h6
`endif

// File: rtl/mcsd_pkg.sv
package mcsd_pkg;
   typedef logic [19:0] mcsd_addr_type;
   typedef logic [15:0] mcsd_reg_type;
   typedef logic [3:0]  mcsd_wait_type;
   typedef enum logic [2:0] {
      MCSD_W_IDLE  = 3'b001,
      MCSD_W_COUNT = 3'b010,
      MCSD_W_DONE  = 3'b100
   } mcsd_wait_state_type;
endpackage : mcsd_pkg

// File: rtl/mcsd_sel_if.sv
`timescale 1ns/100ps
// raw address hits from the decoder, before activation gating
interface mcsd_sel_if;
   logic       low_hit;
   logic [3:0] mid_hit;
   logic [3:0] per_lo_hit;
   logic [1:0] per_hi_hit;
   modport dec (output low_hit, output mid_hit, output per_lo_hit, output per_hi_hit);
   modport use_side (input low_hit, input mid_hit, input per_lo_hit, input per_hi_hit);
endinterface : mcsd_sel_if

// File: rtl/mcsd_decode.sv
`timescale 1ns/100ps
`include "mcsd_consts.svh"
module mcsd_decode (
   input  wire mcsd_pkg::mcsd_addr_type addr_i,
   input  wire logic                    mem_i,
   input  wire mcsd_pkg::mcsd_reg_type  low_cfg_i,
   input  wire mcsd_pkg::mcsd_reg_type  per_cfg_i,
   input  wire mcsd_pkg::mcsd_reg_type  mid_cfg_i,
   input  wire mcsd_pkg::mcsd_reg_type  aux_cfg_i,
   mcsd_sel_if.dec                      sel
);
   import mcsd_pkg::*;

   // quarter index: each select gets a quarter of the one-hot sized block
   function automatic logic [1:0] mid_quarter(input mcsd_addr_type a, input logic [6:0] m);
      logic [1:0] q;
      q = 2'b00;
      for (int k = 0; k < 7; k++) begin
         if (m[k]) begin
            q = a[11 + k +: 2];
         end
      end
      return q;
   endfunction : mid_quarter

   // low region: 00000h up to the boundary given by the mask field
   wire [2:0]    ub       = low_cfg_i[`MCSD_LOW_UB_LSB +: 3];
   assign sel.low_hit = mem_i && !addr_i[19] && ((addr_i[18:16] & ~ub) == 3'h0);

   // midrange: base bits above the block size must match, low bits are zero
   wire [6:0]    size_m   = aux_cfg_i[`MCSD_AUX_SIZE_LSB +: 7];
   wire          size_ok  = (size_m != 7'h00) && ((size_m & (size_m - 7'h01)) == 7'h00);
   wire [6:0]    base_cmp = (addr_i[19:13] ^ mid_cfg_i[`MCSD_MID_BASE_LSB +: 7])
                            & ~(size_m - 7'h01);
   wire          mid_in   = mem_i && size_ok && (base_cmp == 7'h00);
   assign sel.mid_hit = mid_in ? (4'h1 << mid_quarter(addr_i, size_m)) : 4'h0;

   // peripheral: io cycles see only sixteen address bits
   wire [19:0]   per_a    = mem_i ? addr_i : {4'h0, addr_i[15:0]};
   wire          space_ok = (mem_i == aux_cfg_i[`MCSD_AUX_MS_BIT]);
   wire          per_in   = space_ok && (per_a[19:11] == per_cfg_i[`MCSD_PER_BASE_LSB +: 9]);
   wire [2:0]    pos      = per_a[10:8];
   // 256-byte slots; slot four is reserved and slot seven unused
   assign sel.per_lo_hit = (per_in && !pos[2]) ? (4'h1 << pos[1:0]) : 4'h0;
   assign sel.per_hi_hit = {per_in && (pos == `MCSD_PER_UP1_POS),
                            per_in && (pos == `MCSD_PER_UP0_POS)};
endmodule : mcsd_decode

// File: rtl/mcsd_wait.sv
`timescale 1ns/100ps
module mcsd_wait (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   bus_cycle_i,
   input  wire mcsd_pkg::mcsd_wait_type wait_count_i,
   input  wire logic                   ready_ignore_i,
   input  wire logic                   ext_ready_i,
   output logic                        wait_request_o
);
   import mcsd_pkg::*;

   mcsd_wait_state_type state_r, state_nxt;
   mcsd_wait_type       cnt_r, cnt_nxt;
   logic                cycle_q_r;

   wire start  = bus_cycle_i && !cycle_q_r;
   wire go_on  = ready_ignore_i || ext_ready_i;

   // count the programmed waits, then hold for ready unless it is ignored
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         MCSD_W_IDLE: begin
            if (start) begin
               cnt_nxt   = wait_count_i;
               state_nxt = (wait_count_i == 4'h0 && go_on) ? MCSD_W_DONE : MCSD_W_COUNT;
            end
         end
         MCSD_W_COUNT: begin
            if (cnt_r > 4'h1) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               cnt_nxt   = 4'h0;
               state_nxt = go_on ? MCSD_W_DONE : MCSD_W_COUNT;
            end
         end
         MCSD_W_DONE: state_nxt = MCSD_W_DONE;
         default:     state_nxt = MCSD_W_IDLE;
      endcase
      // a cycle that ends early drops the wait at once
      if (!bus_cycle_i) begin
         state_nxt = MCSD_W_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r        <= MCSD_W_IDLE;
         cnt_r          <= 4'h0;
         cycle_q_r      <= 1'b0;
         wait_request_o <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         cnt_r          <= cnt_nxt;
         cycle_q_r      <= bus_cycle_i;
         wait_request_o <= (state_nxt == MCSD_W_COUNT);
      end
   end

   sequence s_two_wait_start;
      start && ready_ignore_i && wait_count_i == 4'h2;
   endsequence
   sequence s_two_waits;
      wait_request_o [*2] ##1 !wait_request_o;
   endsequence
   a_wait_exact: assert property (@(posedge clk_i) disable iff (rst_i)
      s_two_wait_start |=> (bus_cycle_i throughout s_two_waits) or !bus_cycle_i [*1])
      else $error("ignored-ready access did not wait exactly two cycles");
endmodule : mcsd_wait

// File: rtl/mcsd_top.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "mcsd_consts.svh"
module mcsd_top (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // classic wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [9:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // bus-cycle engine side
   input  wire logic                    bus_cycle_i,
   input  wire mcsd_pkg::mcsd_addr_type bus_addr_i,
   input  wire logic                    bus_mem_i,
   input  wire logic                    ext_ready_i,
   input  wire logic                    addr_enable_strap_n_i,
   output logic                         low_select_n_o,
   output logic      [3:0]              midrange_selects_n_o,
   output logic      [3:0]              lower_peripheral_selects_n_o,
   output logic      [1:0]              upper_peripheral_selects_n_o,
   output logic                         wait_request_o,
   output logic                         addr_drive_en_o,
   output logic                         psram_enable_o
);
   import mcsd_pkg::*;

   // byte-lane merge for the 16-bit registers held in the low half-word
   function automatic mcsd_reg_type lane_merge(input mcsd_reg_type old,
                                               input logic [15:0] d,
                                               input logic [1:0] sel);
      lane_merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction : lane_merge

   // three-bit peripheral wait code to a wait count
   function automatic mcsd_wait_type per_wait(input mcsd_reg_type cfg);
      logic [2:0] code;
      code = {cfg[`MCSD_PER_EXT_BIT], cfg[`MCSD_WAIT_LSB +: 2]};
      case (code)
         3'h4:    per_wait = `MCSD_PW_CODE4;
         3'h5:    per_wait = `MCSD_PW_CODE5;
         3'h6:    per_wait = `MCSD_PW_CODE6;
         3'h7:    per_wait = `MCSD_PW_CODE7;
         default: per_wait = {2'b00, code[1:0]};
      endcase
   endfunction : per_wait

   // configuration and activation state
   mcsd_reg_type  low_cfg_r;
   mcsd_reg_type  per_cfg_r;
   mcsd_reg_type  mid_cfg_r;
   mcsd_reg_type  aux_cfg_r;
   logic          low_wr_r;
   logic          per_wr_r;
   logic          mid_wr_r;
   logic          aux_wr_r;
   logic          strap_done_r;
   logic          force_drive_r;
   logic          ack_r;
   logic [31:0]   dat_r;

   // pipeline of the address phase
   logic [3:0]    mid_hit_q_r;
   logic [3:0]    per_lo_q_r;
   logic [1:0]    per_hi_q_r;
   logic [2:1]    addr_q_r;
   logic          low_sel_n_r;
   logic [3:0]    mid_sel_n_r;
   logic [3:0]    per_lo_n_r;
   logic [1:0]    per_hi_n_r;
   logic          drive_r;
   logic          psram_r;

   mcsd_sel_if    hits ();

   // register bus decode
   wire           req       = wb_cyc_i && wb_stb_i;
   wire [7:0]     idx       = wb_adr_i[9:2];
   wire           commit_wr = req && wb_we_i && ack_r;
   wire           hit_low   = (idx == `MCSD_IDX_LOW);
   wire           hit_per   = (idx == `MCSD_IDX_PERIPH);
   wire           hit_mid   = (idx == `MCSD_IDX_MID);
   wire           hit_aux   = (idx == `MCSD_IDX_AUX);
   wire           hit_stat  = (idx == `MCSD_IDX_STATUS);

   // activation terms; nothing drives a select before its registers are written
   wire           low_act    = low_wr_r;
   wire           mid_act    = mid_wr_r && aux_wr_r;
   wire           per_act    = per_wr_r && aux_wr_r;
   wire           pins_as_cs = aux_cfg_r[`MCSD_AUX_EX_BIT];

   // status word shows activation, strap and wait state
   wire [15:0]    status = {9'h000, wait_request_o, force_drive_r, per_act,
                            per_act, mid_act, low_act, pins_as_cs};

   // read multiplexer; unmapped words read as zero and are still acknowledged
   wire [15:0]    rd16 = hit_low  ? low_cfg_r :
                         hit_per  ? per_cfg_r :
                         hit_mid  ? mid_cfg_r :
                         hit_aux  ? aux_cfg_r :
                         hit_stat ? status    : 16'h0000;

   // one wait state on every access: ack one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req && !ack_r;
         if (req && !ack_r) begin
            dat_r <= {16'h0000, rd16};
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // register writes take effect at the edge where ack is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_cfg_r <= `MCSD_REG_RST; // address-disable clears here
         per_cfg_r <= `MCSD_REG_RST;
         mid_cfg_r <= `MCSD_REG_RST;
         aux_cfg_r <= `MCSD_REG_RST;
      end else if (commit_wr) begin
         if (hit_low) low_cfg_r <= lane_merge(low_cfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
         if (hit_per) per_cfg_r <= lane_merge(per_cfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
         if (hit_mid) mid_cfg_r <= lane_merge(mid_cfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
         if (hit_aux) aux_cfg_r <= lane_merge(aux_cfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
   end

   // write-seen flags; any write counts, whatever lanes it carries
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_wr_r <= 1'b0;
         per_wr_r <= 1'b0;
         mid_wr_r <= 1'b0;
         aux_wr_r <= 1'b0;
      end else if (commit_wr) begin
         low_wr_r <= low_wr_r || hit_low;
         per_wr_r <= per_wr_r || hit_per;
         mid_wr_r <= mid_wr_r || hit_mid;
         aux_wr_r <= aux_wr_r || hit_aux;
      end
   end

   // strap is caught on the first clock after reset release, not under reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_done_r  <= 1'b0;
         force_drive_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r  <= 1'b1;
         force_drive_r <= !addr_enable_strap_n_i;
      end
   end

   // address decode is purely combinational on the live address
   mcsd_decode u_decode (
      .addr_i    (bus_addr_i),
      .mem_i     (bus_mem_i),
      .low_cfg_i (low_cfg_r),
      .per_cfg_i (per_cfg_r),
      .mid_cfg_i (mid_cfg_r),
      .aux_cfg_i (aux_cfg_r),
      .sel       (hits.dec)
   );

   // gated hits; overlap of midrange and memory-space peripherals is not arbitrated
   wire           low_on = hits.low_hit && low_act;
   wire [3:0]     mid_on = hits.mid_hit & {4{mid_act}};
   wire [3:0]     plo_on = hits.per_lo_hit & {4{per_act}};
   wire [1:0]     phi_on = hits.per_hi_hit & {2{per_act && pins_as_cs}};

   // stage one: low select and the captured hits for the later selects
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mid_hit_q_r <= 4'h0;
         per_lo_q_r  <= 4'h0;
         per_hi_q_r  <= 2'h0;
         addr_q_r    <= 2'h0;
         low_sel_n_r <= 1'b1;
      end else begin
         mid_hit_q_r <= mid_on & {4{bus_cycle_i}}; // an idle edge leaves no stale hit
         per_lo_q_r  <= plo_on & {4{bus_cycle_i}};
         per_hi_q_r  <= phi_on & {2{bus_cycle_i}};
         addr_q_r    <= bus_addr_i[2:1];
         low_sel_n_r <= !(bus_cycle_i && low_on);
      end
   end

   // stage two: multiplexed-bus timing, one clock behind the low select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mid_sel_n_r <= 4'hf;
         per_lo_n_r  <= 4'hf;
         per_hi_n_r  <= 2'h3;
      end else begin
         mid_sel_n_r <= ~(mid_hit_q_r & {4{bus_cycle_i && mid_act}});
         per_lo_n_r  <= ~(per_lo_q_r & {4{bus_cycle_i && per_act}});
         if (!per_act) begin
            per_hi_n_r <= 2'h3;
         end else if (pins_as_cs) begin
            per_hi_n_r <= ~(per_hi_q_r & {2{bus_cycle_i}});
         end else begin
            per_hi_n_r <= addr_q_r;
         end
      end
   end

   // wait and ready selection; low region wins, then midrange, then peripherals
   wire [1:0]     up_wait   = aux_cfg_r[`MCSD_WAIT_LSB +: 2];
   mcsd_wait_type wsel_cnt;
   logic          wsel_ign;
   assign wsel_cnt = low_on          ? {2'b00, low_cfg_r[`MCSD_WAIT_LSB +: 2]} :
                     (mid_on != 4'h0) ? {2'b00, mid_cfg_r[`MCSD_WAIT_LSB +: 2]} :
                     (phi_on != 2'h0) ? {2'b00, up_wait} :
                     (plo_on != 4'h0) ? per_wait(per_cfg_r) : 4'h0;
   // unselected cycles run with no waits and wait for external ready
   assign wsel_ign = low_on          ? low_cfg_r[`MCSD_READY_BIT] :
                     (mid_on != 4'h0) ? mid_cfg_r[`MCSD_READY_BIT] :
                     (phi_on != 2'h0) ? aux_cfg_r[`MCSD_READY_BIT] :
                     (plo_on != 4'h0) ? per_cfg_r[`MCSD_READY_BIT] : 1'b0;

   mcsd_wait u_wait (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .bus_cycle_i    (bus_cycle_i),
      .wait_count_i   (wsel_cnt),
      .ready_ignore_i (wsel_ign),
      .ext_ready_i    (ext_ready_i),
      .wait_request_o (wait_request_o)
   );

   // address drive follows the low-memory register unless the strap forces it on; psram control follows that register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_r <= 1'b1;
         psram_r <= 1'b0;
      end else begin
         drive_r <= force_drive_r || !low_cfg_r[`MCSD_LOW_DA_BIT];
         psram_r <= low_act && low_cfg_r[`MCSD_LOW_PSE_BIT];
      end
   end

   assign low_select_n_o               = low_sel_n_r;
   assign midrange_selects_n_o         = mid_sel_n_r;
   assign lower_peripheral_selects_n_o = per_lo_n_r;
   assign upper_peripheral_selects_n_o = per_hi_n_r;
   assign addr_drive_en_o              = drive_r;
   assign psram_enable_o               = psram_r;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_mid_inactive: assert property (!mid_act |=> midrange_selects_n_o == 4'hf)
      else $error("midrange select asserted before activation");

   a_mid_late_timing: assert property ($rose(bus_cycle_i) |=> &midrange_selects_n_o)
      else $error("midrange select asserted in the low select cycle");

   a_low_inactive: assert property (!low_act |=> low_select_n_o)
      else $error("low select asserted before its register was written");

   a_low_range: assert property (!low_select_n_o |->
      $past(bus_mem_i) && !$past(bus_addr_i[19]))
      else $error("low select asserted outside the low region");

   a_per_space: assert property (lower_peripheral_selects_n_o != 4'hf |->
      $past(bus_mem_i, 2) == $past(aux_cfg_r[`MCSD_AUX_MS_BIT], 2))
      else $error("peripheral select asserted on the wrong space");

   a_per_inactive: assert property (!per_act |=>
      lower_peripheral_selects_n_o == 4'hf && upper_peripheral_selects_n_o == 2'h3)
      else $error("peripheral pins active before activation");

   a_upper_addr_pins: assert property (per_act && !pins_as_cs && $stable(aux_cfg_r) |=>
      upper_peripheral_selects_n_o == $past(bus_addr_i[2:1], 2))
      else $error("upper pins do not carry latched a2 and a1");

   a_per_wait_top: assert property (plo_on != 4'h0 && !low_on && mid_on == 4'h0 &&
      phi_on == 2'h0 && per_cfg_r[3] && per_cfg_r[1:0] == 2'h3 |-> wsel_cnt == 4'hf)
      else $error("peripheral wait code 111b did not give fifteen waits");

   a_strap_drive: assert property (force_drive_r |=> addr_drive_en_o)
      else $error("strapped address drive was disabled");

   // register bus: a taken request is acknowledged after one wait, for one cycle only
   sequence s_wb_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_wb_one_wait: assert property (s_wb_taken |=> wb_ack_o ##1 !wb_ack_o)
      else $error("register access not acknowledged after exactly one wait");

   // a midrange hit held for two edges shows on its pin in the second stage
   sequence s_mid_hit_held;
      bus_cycle_i && mid_on != 4'h0 ##1 bus_cycle_i && $stable(mid_on);
   endsequence
   a_mid_select_on: assert property (s_mid_hit_held |=>
      midrange_selects_n_o == ~$past(mid_on))
      else $error("midrange select did not follow its quarter");

   // upper slots used as selects follow the same two-stage timing
   sequence s_upper_hit_held;
      bus_cycle_i && phi_on != 2'h0 ##1 bus_cycle_i && $stable(phi_on);
   endsequence
   a_upper_select_on: assert property (s_upper_hit_held |=>
      upper_peripheral_selects_n_o == ~$past(phi_on))
      else $error("upper peripheral select did not follow its slot");

   // psram support stays off while the low region is not activated
   a_psram_off: assert property (!low_act |=> !psram_enable_o)
      else $error("psram support on before the low register was written");
endmodule : mcsd_top

// File: verification/mcsd_mem_model.sv
`timescale 1ns/100ps
// slow memory or peripheral: answers ready a set number of cycles after a select falls
module mcsd_mem_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       sel_n_i,
   input  wire logic [3:0] lat_i,
   output logic            ready_o
);
   logic [3:0] cnt_r;
   // count saturates so a stalled access cannot wrap back into a false early ready
   always_ff @(posedge clk_i) begin
      if (rst_i || sel_n_i) cnt_r <= 4'h0;
      else if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
   end
   // ready held low while nothing is selected, as an unaddressed bus would be
   assign ready_o = !sel_n_i && (cnt_r >= lat_i);
endmodule : mcsd_mem_model

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, strap_n, rdy;
   logic        bus_cycle_i, bus_mem_i, low_n, wreq, drive_en, psram;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, mid_n, plo_n, lat;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [19:0] bus_addr_i;
   logic [1:0]  phi_n;
   logic [15:0] q;
   int          error_cnt, n_tests, w, k;
   wire  [10:0] sels = {low_n, mid_n, plo_n, phi_n};
   // boundary codes, region ends, midrange probes and peripheral wait table
   logic [2:0]  ubc [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
   logic [19:0] ube [4] = '{20'h7ffff, 20'h3ffff, 20'h1ffff, 20'h0ffff};
   logic [19:0] ma [6] = '{20'h30000, 20'h27fff, 20'h28000, 20'h2bfff, 20'h2c000, 20'h2ffff};
   logic [3:0]  mn [6] = '{4'hf, 4'hf, 4'he, 4'hd, 4'hb, 4'h7};
   logic [15:0] pw [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h5, 16'h7, 16'h9, 16'hf};
   logic [10:0] po [7] = '{11'h000, 11'h2ff, 11'h3ff, 11'h400, 11'h700, 11'h6ff, 11'h500};
   logic [10:0] pe [7] = '{11'h7fb, 11'h7ef, 11'h7df, 11'h7ff, 11'h7ff, 11'h7fd, 11'h7fe};

   mcsd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_cycle_i(bus_cycle_i),
      .bus_addr_i(bus_addr_i), .bus_mem_i(bus_mem_i), .ext_ready_i(rdy),
      .addr_enable_strap_n_i(strap_n), .low_select_n_o(low_n), .midrange_selects_n_o(mid_n),
      .lower_peripheral_selects_n_o(plo_n), .upper_peripheral_selects_n_o(phi_n),
      .wait_request_o(wreq), .addr_drive_en_o(drive_en), .psram_enable_o(psram));
   mcsd_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .sel_n_i(&sels), .lat_i(lat),
      .ready_o(rdy));

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one classic wishbone access; the ack wait is bounded so a dead slave cannot hang us
   task automatic wb(input logic [7:0] idx, input logic we, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, 16'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      q = wb_dat_o[15:0];
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge clk_i);
   endtask : wb
   // one bus cycle: selects checked in its first two cycles, wait cycles counted into w
   task automatic run(input logic [19:0] a, input logic m, input logic [10:0] e);
      @(posedge clk_i);
      {bus_cycle_i, bus_mem_i, bus_addr_i} <= {1'b1, m, a};
      w = 0;
      for (int j = 1; j < 24; j++) begin
         @(posedge clk_i);
         #1;
         if (j == 1) chk("early", {low_n, mid_n}, {e[10], 4'hf});
         if (j == 2) chk("selects", sels, e);
         if (wreq === 1'b1) w++;
      end
      @(posedge clk_i);
      bus_cycle_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("release", {low_n, mid_n, plo_n}, 9'h1ff);
   endtask : run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // the sequence needs about 1150 cycles; allow about seventeen times that
   initial begin
      #80000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, bus_cycle_i, bus_mem_i, strap_n} = 7'b1000001;
      {wb_adr_i, wb_sel_i, wb_dat_i, bus_addr_i, lat} = {10'h0, 4'h3, 32'h0, 20'h0, 4'h6};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("reset", {sels, wb_ack_o, drive_en, psram}, {11'h7ff, 3'b010});
      run(20'h00100, 1'b1, 11'h7ff);
      // low region: every boundary code with a different wait count, both sides of the end
      for (k = 0; k < 4; k++) begin
         wb(8'ha2, 1'b1, {1'b0, ubc[k], 9'h000, 1'b1, k[1:0]});
         run(ube[k], 1'b1, 11'h3ff);
         chk("low_waits", w[15:0], k[15:0]);
         run(ube[k] + 20'h1, 1'b1, 11'h7ff);
      end
      wb(8'ha2, 1'b1, 16'h00c6);
      #1;
      chk("drive_psram", {drive_en, psram}, 2'b01);
      wb(8'ha2, 1'b0, 16'h0);
      chk("low_cfg", q, 16'h00c6);
      wb(8'ha2, 1'b1, 16'h0001);
      run(20'h00010, 1'b1, 11'h3ff);
      chk("low_ready", w > 1, 1);
      wb(8'ha2, 1'b1, 16'h0004);
      // midrange: 32K block at a block multiple, live only after both writes
      wb(8'ha8, 1'b1, 16'h04c5);
      run(20'h28000, 1'b1, 11'h7ff);
      wb(8'ha6, 1'b1, 16'h2807);
      for (k = 0; k < 6; k++) run(ma[k], 1'b1, {1'b1, mn[k], 6'h3f});
      chk("mid_waits", w[15:0], 16'h3);
      wb(8'ha6, 1'b1, 16'h2801);
      run(20'h2e000, 1'b1, {1'b1, 4'h7, 6'h3f});
      chk("mid_ready", w > 1, 1);
      // peripherals in memory space, then every wait code, then every slot but slot one
      run(20'h40000, 1'b1, 11'h7ff);
      for (k = 0; k < 8; k++) begin
         wb(8'ha4, 1'b1, {9'h080, 3'h0, k[2], 1'b1, k[1:0]});
         run(20'h40100, 1'b1, 11'h7f7);
         chk("per_waits", w[15:0], pw[k]);
      end
      for (k = 0; k < 7; k++) run(20'h40000 + po[k], 1'b1, pe[k]);
      chk("upper_waits", w[15:0], 16'h1);
      // io space with upper base bits zero; memory cycle at the same address takes the low select
      wb(8'ha8, 1'b1, 16'h0485);
      wb(8'ha4, 1'b1, 16'h0004);
      run(20'h00300, 1'b0, 11'h7df);
      run(20'h00300, 1'b1, 11'h3ff);
      wb(8'ha4, 1'b0, 16'h0);
      chk("per_cfg", q, 16'h0004);
      wb(8'ha8, 1'b1, 16'h0445);
      run(20'h80004, 1'b1, 11'h7fe);
      wb(8'hb0, 1'b1, 16'hffff);
      wb(8'hb0, 1'b0, 16'h0);
      chk("unmapped", q, 16'h0);
      // second reset with the strap low: address drive can no longer be turned off
      strap_n <= 1'b0;
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // 512K midrange block at base zero while the low select is still inactive
      wb(8'ha8, 1'b1, 16'h4084);
      wb(8'ha6, 1'b1, 16'h0004);
      run(20'h40000, 1'b1, {1'b1, 4'hb, 6'h3f});
      chk("big_waits", w[15:0], 16'h0);
      wb(8'ha2, 1'b1, 16'h0080);
      #1;
      chk("strap", drive_en, 1'b1);
      wb(8'haa, 1'b0, 16'h0);
      chk("status", q, 16'h0027);
      tally_and_finish();
   end
endmodule : tb
